/* rtl/fifo_consts.vh */
// constants for the dual-clock fifo with programmable flags
`ifndef FIFO_CONSTS_VH
`define FIFO_CONSTS_VH

`define DATA_W       9
`define ADDR_W       14
`define PTR_W        15
`define DEPTH        15'h4000
`define OFS_W        18
`define PAD_W        3
`define DEF_OFS_LO   9'h007
`define DEF_OFS_HI   9'h000

`define IDX_E_LO     2'h0
`define IDX_E_HI     2'h1
`define IDX_F_LO     2'h2
`define IDX_F_HI     2'h3

`define AXI_AW       5
`define REG_CTRL     5'h00
`define REG_STATUS   5'h04
`define REG_E_OFS    5'h08
`define REG_F_OFS    5'h0c
`define CTRL_CLEAR   0
`define ST_FULL_N    0
`define ST_AFULL_N   1
`define ST_MODE      2
`define ST_CNT_LSB   8
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

/* rtl/dual_clock_fifo_prog_flags.v */
// dual-clock fifo with programmable almost flags and axi4-lite status
//
// How it works
// - input and output words are nine bits wide.
// - programmable-flag mode: primary enable low, load high and not full stores the input word.
// - dual-enable mode: primary low, secondary high and not full stores the word.
// - secondary/load pin level during clear selects dual-enable or offset-load mode.
// - no write reaches storage while the full indicator is low.
// - with load asserted, write edges store the input word in an offset register.
// - both read enables low and not empty presents the next stored word.
// - with load low, read edges put offset register contents on the output.
// - empty indicator low when nothing unread, updated on the read clock.
// - full indicator low when storage is full, updated on the write clock.
// - almost-empty indicator follows the empty offset, on the read clock.
// - almost-full indicator follows the full offset, on the write clock.
// - master clear empties the buffer and resets both pointers.
// - output enable low sets output_word_oe_n low, high sets it high; output_word itself is always driven.
// - storage is a dual-port array of 16K words with separate pointers.
// - offset loads cycle empty low, empty high, full low, full high, then wrap.
// - almost-empty low at n or fewer words, high from n+1.
// - almost-full low at depth minus m or more words, high when free exceeds m.
// - both offsets default to seven.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "fifo_consts.vh"

module dual_clock_fifo_prog_flags (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire                 rd_clk,
	input  wire                 master_clear_n,
	input  wire [`DATA_W-1:0]   input_word,
	input  wire                 write_enable_primary_n,
	input  wire                 write_enable_secondary_or_load,
	input  wire                 read_enable_a_n,
	input  wire                 read_enable_b_n,
	input  wire                 output_drive_enable_n,
	output wire [`DATA_W-1:0]   output_word,
	output wire                 output_word_oe_n,
	output wire                 full_indicator_n,
	output wire                 almost_full_indicator_n,
	output wire                 empty_indicator_n,
	output wire                 almost_empty_indicator_n,
	input  wire [`AXI_AW-1:0]   s_axi_awaddr,
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	output wire [1:0]           s_axi_bresp,
	output wire                 s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [`AXI_AW-1:0]   s_axi_araddr,
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	output wire [31:0]          s_axi_rdata,
	output wire [1:0]           s_axi_rresp,
	output wire                 s_axi_rvalid,
	input  wire                 s_axi_rready
);

	function [`PTR_W-1:0] gray2bin;
		input [`PTR_W-1:0] g;
		integer i;
		begin
			gray2bin[`PTR_W-1] = g[`PTR_W-1];
			for (i = `PTR_W-2; i >= 0; i = i - 1) begin
				gray2bin[i] = gray2bin[i+1] ^ g[i];
			end
		end
	endfunction

	function [`PTR_W-1:0] bin2gray;
		input [`PTR_W-1:0] b;
		begin
			bin2gray = b ^ (b >> 1);
		end
	endfunction

	reg [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];

	// read pointer in gray, driven on rd_clk
	reg [`PTR_W-1:0]    rd_gray_reg;

	// write domain state
	reg                 ctrl_clear_reg;
	reg                 wr_clear_reg;
	reg                 dual_mode_reg;
	reg [`PTR_W-1:0]    wr_bin_reg;
	reg [`PTR_W-1:0]    wr_gray_reg;
	reg [`PTR_W-1:0]    rgray_w1_reg;
	reg [`PTR_W-1:0]    rgray_w2_reg;
	reg [1:0]           ofs_widx_reg;
	reg [8:0]           e_lo_reg;
	reg [8:0]           e_hi_reg;
	reg [8:0]           f_lo_reg;
	reg [8:0]           f_hi_reg;
	reg                 full_n_reg;
	reg                 afull_n_reg;
	reg [`PTR_W-1:0]    wcount_reg;

	wire                wr_clear = !aresetn || !master_clear_n || ctrl_clear_reg;
	wire                prog_mode = !dual_mode_reg;
	wire                load_act = prog_mode && !write_enable_secondary_or_load;
	wire                wr_do = !write_enable_primary_n && write_enable_secondary_or_load &&
	                            full_n_reg;
	wire                ofs_wr = load_act && !write_enable_primary_n;
	wire [`PTR_W-1:0]   wr_bin_next = wr_bin_reg + {{(`PTR_W-1){1'b0}}, wr_do};
	wire [`PTR_W-1:0]   rd_bin_w = gray2bin(rgray_w2_reg);
	wire [`PTR_W-1:0]   wcount_next = wr_bin_next - rd_bin_w;
	wire [`OFS_W-1:0]   m_ofs = {f_hi_reg, f_lo_reg};
	wire [`OFS_W:0]     wsum = {1'b0, {`PAD_W{1'b0}}, wcount_next} + {1'b0, m_ofs};

	always @(posedge aclk) begin
		wr_clear_reg <= wr_clear;
		if (wr_clear) begin
			dual_mode_reg <= write_enable_secondary_or_load;
			wr_bin_reg    <= {`PTR_W{1'b0}};
			wr_gray_reg   <= {`PTR_W{1'b0}};
			rgray_w1_reg  <= {`PTR_W{1'b0}};
			rgray_w2_reg  <= {`PTR_W{1'b0}};
			ofs_widx_reg  <= `IDX_E_LO;
			e_lo_reg      <= `DEF_OFS_LO;
			e_hi_reg      <= `DEF_OFS_HI;
			f_lo_reg      <= `DEF_OFS_LO;
			f_hi_reg      <= `DEF_OFS_HI;
			full_n_reg    <= 1'b1;
			afull_n_reg   <= 1'b1;
			wcount_reg    <= {`PTR_W{1'b0}};
		end else begin
			rgray_w1_reg <= rd_gray_reg;
			rgray_w2_reg <= rgray_w1_reg;
			if (wr_do) begin
				mem[wr_bin_reg[`ADDR_W-1:0]] <= input_word;
			end
			wr_bin_reg  <= wr_bin_next;
			wr_gray_reg <= bin2gray(wr_bin_next);
			if (ofs_wr) begin
				case (ofs_widx_reg)
					`IDX_E_LO: e_lo_reg <= input_word;
					`IDX_E_HI: e_hi_reg <= input_word;
					`IDX_F_LO: f_lo_reg <= input_word;
					default:   f_hi_reg <= input_word;
				endcase
				ofs_widx_reg <= ofs_widx_reg + 2'h1;
			end
			full_n_reg  <= !(wcount_next == `DEPTH);
			afull_n_reg <= !(wsum >= {{(`OFS_W-`PTR_W+1){1'b0}}, `DEPTH});
			wcount_reg  <= wcount_next;
		end
	end

	// read domain state
	reg                 rclr_s1_reg;
	reg                 rclr_s2_reg;
	reg                 mode_s1_reg;
	reg                 mode_s2_reg;
	reg                 ld_s1_reg;
	reg                 ld_s2_reg;
	reg                 ld_s3_reg;
	reg                 ld_reg;
	reg                 oe_s1_reg;
	reg                 oe_s2_reg;
	reg                 oe_s3_reg;
	reg                 oe_n_reg;
	reg [4*9-1:0]       ofs_s1_reg;
	reg [4*9-1:0]       ofs_s2_reg;
	reg [`PTR_W-1:0]    wgray_r1_reg;
	reg [`PTR_W-1:0]    wgray_r2_reg;
	reg [`PTR_W-1:0]    rd_bin_reg;
	reg [1:0]           ofs_ridx_reg;
	reg [`DATA_W-1:0]   out_reg;
	reg                 empty_n_reg;
	reg                 aempty_n_reg;

	wire                rd_rst = rclr_s2_reg;
	wire                rd_prog = !mode_s2_reg;
	wire                rd_en = !read_enable_a_n && !read_enable_b_n;
	wire                ofs_rd = rd_prog && ld_reg && rd_en;
	wire                rd_do = rd_en && !ofs_rd && empty_n_reg;
	wire [`PTR_W-1:0]   rd_bin_next = rd_bin_reg + {{(`PTR_W-1){1'b0}}, rd_do};
	wire [`PTR_W-1:0]   wr_bin_r = gray2bin(wgray_r2_reg);
	wire [`PTR_W-1:0]   rcount_next = wr_bin_r - rd_bin_next;
	wire [`OFS_W-1:0]   n_ofs = {ofs_s2_reg[17:9], ofs_s2_reg[8:0]};

	always @(posedge rd_clk) begin
		rclr_s1_reg <= wr_clear_reg;
		rclr_s2_reg <= rclr_s1_reg;
		mode_s1_reg <= dual_mode_reg;
		mode_s2_reg <= mode_s1_reg;
		ofs_s1_reg  <= {f_hi_reg, f_lo_reg, e_hi_reg, e_lo_reg};
		ofs_s2_reg  <= ofs_s1_reg;
		ld_s1_reg   <= !write_enable_secondary_or_load;
		ld_s2_reg   <= ld_s1_reg;
		ld_s3_reg   <= ld_s2_reg;
		oe_s1_reg   <= output_drive_enable_n;
		oe_s2_reg   <= oe_s1_reg;
		oe_s3_reg   <= oe_s2_reg;
		if (rd_rst) begin
			ld_reg       <= 1'b0;
			oe_n_reg     <= 1'b1;
			wgray_r1_reg <= {`PTR_W{1'b0}};
			wgray_r2_reg <= {`PTR_W{1'b0}};
			rd_bin_reg   <= {`PTR_W{1'b0}};
			rd_gray_reg  <= {`PTR_W{1'b0}};
			ofs_ridx_reg <= `IDX_E_LO;
			out_reg      <= {`DATA_W{1'b0}};
			empty_n_reg  <= 1'b0;
			aempty_n_reg <= 1'b0;
		end else begin
			if (ld_s2_reg == ld_s3_reg) begin
				ld_reg <= ld_s3_reg;
			end
			if (oe_s2_reg == oe_s3_reg) begin
				oe_n_reg <= oe_s3_reg;
			end
			wgray_r1_reg <= wr_gray_reg;
			wgray_r2_reg <= wgray_r1_reg;
			if (ofs_rd) begin
				case (ofs_ridx_reg)
					`IDX_E_LO: out_reg <= ofs_s2_reg[8:0];
					`IDX_E_HI: out_reg <= ofs_s2_reg[17:9];
					`IDX_F_LO: out_reg <= ofs_s2_reg[26:18];
					default:   out_reg <= ofs_s2_reg[35:27];
				endcase
				ofs_ridx_reg <= ofs_ridx_reg + 2'h1;
			end else if (rd_do) begin
				out_reg <= mem[rd_bin_reg[`ADDR_W-1:0]];
			end
			rd_bin_reg   <= rd_bin_next;
			rd_gray_reg  <= bin2gray(rd_bin_next);
			empty_n_reg  <= !(rcount_next == {`PTR_W{1'b0}});
			aempty_n_reg <= ({{`PAD_W{1'b0}}, rcount_next} > n_ofs);
		end
	end

	// axi4-lite slave on the write clock
	reg                 awready_reg;
	reg                 wready_reg;
	reg                 bvalid_reg;
	reg [1:0]           bresp_reg;
	reg [`AXI_AW-1:0]   awaddr_reg;
	reg                 aw_held_reg;
	reg [31:0]          wdata_reg;
	reg                 w_held_reg;
	reg                 arready_reg;
	reg                 rvalid_reg;
	reg [31:0]          rdata_reg;
	reg [1:0]           rresp_reg;

	wire                aw_take = s_axi_awvalid && awready_reg;
	wire                w_take = s_axi_wvalid && wready_reg;
	wire                aw_ok = aw_held_reg || aw_take;
	wire                w_ok = w_held_reg || w_take;
	wire [`AXI_AW-1:0]  waddr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0]         wdat = w_held_reg ? wdata_reg : s_axi_wdata;
	wire                wr_fire = aw_ok && w_ok && !bvalid_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg    <= 1'b1;
			wready_reg     <= 1'b1;
			aw_held_reg    <= 1'b0;
			w_held_reg     <= 1'b0;
			awaddr_reg     <= {`AXI_AW{1'b0}};
			wdata_reg      <= 32'h0;
			bvalid_reg     <= 1'b0;
			bresp_reg      <= `RESP_OKAY;
			ctrl_clear_reg <= 1'b0;
		end else begin
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				awready_reg <= 1'b0;
				wready_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				if (waddr == `REG_CTRL) begin
					bresp_reg <= `RESP_OKAY;
					if (s_axi_wstrb[0]) begin
						ctrl_clear_reg <= wdat[`CTRL_CLEAR];
					end
				end else if (waddr == `REG_STATUS || waddr == `REG_E_OFS ||
				             waddr == `REG_F_OFS) begin
					bresp_reg <= `RESP_OKAY;
				end else begin
					bresp_reg <= `RESP_SLVERR;
				end
			end else begin
				if (aw_take) begin
					aw_held_reg <= 1'b1;
					awaddr_reg  <= s_axi_awaddr;
					awready_reg <= 1'b0;
				end
				if (w_take) begin
					w_held_reg <= 1'b1;
					wdata_reg  <= s_axi_wdata;
					wready_reg <= 1'b0;
				end
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= `RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rresp_reg   <= `RESP_OKAY;
			if (s_axi_araddr == `REG_CTRL) begin
				rdata_reg <= {31'h0, ctrl_clear_reg};
			end else if (s_axi_araddr == `REG_STATUS) begin
				rdata_reg <= {{(32-`ST_CNT_LSB-`PTR_W){1'b0}}, wcount_reg, 5'h0,
				              dual_mode_reg, afull_n_reg, full_n_reg};
			end else if (s_axi_araddr == `REG_E_OFS) begin
				rdata_reg <= {14'h0, e_hi_reg, e_lo_reg};
			end else if (s_axi_araddr == `REG_F_OFS) begin
				rdata_reg <= {14'h0, f_hi_reg, f_lo_reg};
			end else begin
				rdata_reg <= 32'h0;
				rresp_reg <= `RESP_SLVERR;
			end
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	assign output_word              = out_reg;
	assign output_word_oe_n         = oe_n_reg;
	assign full_indicator_n         = full_n_reg;
	assign almost_full_indicator_n  = afull_n_reg;
	assign empty_indicator_n        = empty_n_reg;
	assign almost_empty_indicator_n = aempty_n_reg;
	assign s_axi_awready            = awready_reg;
	assign s_axi_wready             = wready_reg;
	assign s_axi_bresp              = bresp_reg;
	assign s_axi_bvalid             = bvalid_reg;
	assign s_axi_arready            = arready_reg;
	assign s_axi_rdata              = rdata_reg;
	assign s_axi_rresp              = rresp_reg;
	assign s_axi_rvalid             = rvalid_reg;

endmodule

`default_nettype wire

/* dv/fifo_checker.sv */
// checker for the dual-clock fifo ports
`timescale 1ns/100ps
`default_nettype none
`include "fifo_consts.vh"
module fifo_checker (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              rd_clk,
	input wire logic              master_clear_n,
	input wire logic              full_indicator_n,
	input wire logic              almost_full_indicator_n,
	input wire logic              empty_indicator_n,
	input wire logic              almost_empty_indicator_n,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [`AXI_AW-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic [31:0]       s_axi_rdata
);
	a_full_means_af: assert property (@(posedge aclk) disable iff (!aresetn)
		!full_indicator_n |-> !almost_full_indicator_n) else $error("full without almost full");
	a_empty_means_ae: assert property (@(posedge rd_clk) disable iff (!aresetn)
		!empty_indicator_n |-> !almost_empty_indicator_n) else $error("empty without almost empty");
	a_reset_write_flags: assert property (@(posedge aclk)
		!aresetn |=> full_indicator_n && almost_full_indicator_n) else $error("write flags in clear");
	a_reset_read_flags: assert property (@(posedge rd_clk)
		!master_clear_n [*6] |=> !empty_indicator_n) else $error("not empty after clear");
	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("no write response");
	a_bvalid_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
	a_rdata_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_unmapped_error: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h0c |=> s_axi_rresp == `RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule
bind dual_clock_fifo_prog_flags fifo_checker fifo_checker_i (.aclk(aclk), .aresetn(aresetn),
	.rd_clk(rd_clk), .master_clear_n(master_clear_n), .full_indicator_n(full_indicator_n),
	.almost_full_indicator_n(almost_full_indicator_n), .empty_indicator_n(empty_indicator_n),
	.almost_empty_indicator_n(almost_empty_indicator_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

/* dv/fifo_reader.sv */
// reader-side partner on the read clock
`timescale 1ns/100ps
`default_nettype none
module fifo_reader (
	input wire logic       rd_clk,
	input wire logic       go,
	input wire logic       ofs_mode,
	input wire logic       empty_n,
	input wire logic [8:0] word,
	output var logic       ren_a_n = 1'b1,
	output var logic       ren_b_n = 1'b1
);
	logic [8:0] got[$];
	logic       hit = 0;
	always @(posedge rd_clk) begin
		if (hit)
			got.push_back(word);
		hit <= !ren_a_n && !ren_b_n && (empty_n || ofs_mode);
		ren_a_n <= !go;
		ren_b_n <= !go;
	end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the dual-clock fifo
`timescale 1ns/100ps
`default_nettype none
`include "fifo_consts.vh"
module tb_top;
	logic aclk = 0, rd_clk = 0, aresetn = 0, clr_n = 0, wen_n = 1, sec = 1, oe_in = 0, go = 0;
	logic ofs_mode = 0;
	logic [8:0] din = 0;
	logic [8:0] ofs [5] = '{9'h002, 9'h000, 9'h003, 9'h000, 9'h001};
	logic [4:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rd;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [1:0] resp;
	wire [8:0] q;
	wire ren_a_n, ren_b_n, oe_n, full_n, af_n, empty_n, ae_n;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int n_errors = 0, check_count = 0, cyc = 0, rbase = 0;
	always #5 aclk = ~aclk;
	always #7 rd_clk = ~rd_clk;
	dual_clock_fifo_prog_flags dual_clock_fifo_prog_flags_i (.aclk(aclk), .aresetn(aresetn),
		.rd_clk(rd_clk), .master_clear_n(clr_n), .input_word(din),
		.write_enable_primary_n(wen_n), .write_enable_secondary_or_load(sec),
		.read_enable_a_n(ren_a_n), .read_enable_b_n(ren_b_n), .output_drive_enable_n(oe_in),
		.output_word(q), .output_word_oe_n(oe_n), .full_indicator_n(full_n),
		.almost_full_indicator_n(af_n), .empty_indicator_n(empty_n),
		.almost_empty_indicator_n(ae_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	fifo_reader fifo_reader_i (.rd_clk(rd_clk), .go(go), .ofs_mode(ofs_mode), .empty_n(empty_n),
		.word(q),
		.ren_a_n(ren_a_n), .ren_b_n(ren_b_n));
	task give_verdict;
		if (n_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(negedge aclk);
			aw = awready;
			w = wready;
			b = bvalid;
			r = bresp;
			@(posedge aclk);
			if (aw)
				awvalid <= 0;
			if (w)
				wvalid <= 0;
			if (b) begin
				bready <= 0;
				break;
			end
		end
		@(posedge aclk);
	endtask
	task axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, v;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(negedge aclk);
			ar = arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar)
				arvalid <= 0;
			if (v) begin
				rready <= 0;
				break;
			end
		end
		@(posedge aclk);
	endtask
	task wr(input int n, input logic [8:0] v);
		for (int i = 0; i < n; i++) begin
			din <= v + 9'(i);
			wen_n <= 0;
			@(posedge aclk);
		end
		wen_n <= 1;
		@(posedge aclk);
	endtask
	task clr(input logic mode);
		clr_n <= 0;
		sec <= mode;
		repeat (10) @(posedge aclk);
		clr_n <= 1;
		sec <= 1;
		repeat (10) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		clr_n <= 1;
		repeat (8) @(posedge aclk);
		axi_rd(`REG_STATUS, rd, resp);
		chk(rd, 32'h7);
		chk(empty_n, 0);
		chk(ae_n, 0);
		sec <= 0;
		wr(1, 9'h1aa);
		sec <= 1;
		wr(7, 9'h100);
		repeat (10) @(posedge aclk);
		chk(empty_n, 1);
		chk(ae_n, 0);
		wr(1, 9'h107);
		repeat (10) @(posedge aclk);
		chk(ae_n, 1);
		axi_rd(`REG_STATUS, rd, resp);
		chk(rd, 32'h807);
		go <= 1;
		for (int i = 0; i < 60 && fifo_reader_i.got.size() < 8; i++)
			@(posedge aclk);
		repeat (10) @(posedge aclk);
		go <= 0;
		chk(fifo_reader_i.got.size(), 8);
		foreach (fifo_reader_i.got[i])
			chk(fifo_reader_i.got[i], 9'h100 + 9'(i));
		chk(q, 9'h107);
		chk(empty_n, 0);
		chk(oe_n, 0);
		oe_in <= 1;
		repeat (10) @(posedge aclk);
		chk(oe_n, 1);
		oe_in <= 0;
		clr(0);
		axi_rd(`REG_STATUS, rd, resp);
		chk(rd, 32'h3);
		sec <= 0;
		foreach (ofs[i]) begin
			wr(1, ofs[i]);
			@(posedge aclk);
		end
		sec <= 1;
		repeat (8) @(posedge aclk);
		axi_rd(`REG_E_OFS, rd, resp);
		chk(rd, 32'h1);
		axi_rd(`REG_F_OFS, rd, resp);
		chk(rd, 32'h3);
		sec <= 0;
		ofs_mode <= 1;
		rbase = fifo_reader_i.got.size();
		repeat (10) @(posedge aclk);
		go <= 1;
		repeat (10) @(posedge aclk);
		go <= 0;
		repeat (10) @(posedge aclk);
		sec <= 1;
		ofs_mode <= 0;
		chk(fifo_reader_i.got[rbase], 32'h1);
		chk(fifo_reader_i.got[rbase+1], 32'h0);
		chk(fifo_reader_i.got[rbase+2], 32'h3);
		chk(fifo_reader_i.got[rbase+3], 32'h0);
		repeat (8) @(posedge aclk);
		wr(16380, 9'h000);
		repeat (4) @(posedge aclk);
		chk(af_n, 1);
		wr(1, 9'h000);
		repeat (2) @(posedge aclk);
		chk(af_n, 0);
		chk(full_n, 1);
		wr(3, 9'h000);
		repeat (2) @(posedge aclk);
		chk(full_n, 0);
		wr(1, 9'h000);
		repeat (10) @(posedge aclk);
		axi_rd(`REG_STATUS, rd, resp);
		chk(rd, 32'h400000);
		chk(ae_n, 1);
		axi_wr(`REG_CTRL, 32'h1, resp);
		chk(resp, `RESP_OKAY);
		repeat (10) @(posedge aclk);
		axi_wr(`REG_CTRL, 32'h0, resp);
		repeat (10) @(posedge aclk);
		axi_rd(`REG_STATUS, rd, resp);
		chk(rd & ~32'h4, 32'h3);
		chk(empty_n, 0);
		axi_rd(5'h10, rd, resp);
		chk(resp, `RESP_SLVERR);
		give_verdict();
	end
endmodule
`default_nettype wire
